// File: lfp_pkg.sv
// Shared constants for the LED channel fault protection block.
package lfp_pkg;

  localparam int          NUM_CH          = 2;
  localparam int          CODE_W          = 4;
  localparam logic [3:0]  SHORT_CODE_RST  = 4'h2;
  localparam logic [3:0]  SHORT_CODE_TOP  = 4'h0;
  localparam int          LVL_W           = 10;
  // Threshold levels in millivolts; codes 1..15 step linearly from the base.
  localparam logic [9:0]  SHORT_BASE_MV   = 10'd45;
  localparam logic [9:0]  SHORT_STEP_MV   = 10'd45;
  localparam logic [9:0]  SHORT_TOP_MV    = 10'd726;
  localparam int          VFB_SHORT_CYC   = 8;
  localparam int          BOOST_SHORT_CYC = 2;
  localparam int          OPEN_LOAD_CYC   = 8;
  localparam int          CNT_W           = 4;
  localparam int          MON_W           = 2;
  localparam int          DAC_W           = 8;

endpackage : lfp_pkg

// File: lfp_filter.sv
// Persistence filter: output rises after the input has held high for a set count.
module lfp_filter #(
  parameter int CYCLES = 8
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic sys_rst,
  // Condition.
  input  wire logic cond,
  output logic      hit
);

  logic [lfp_pkg::CNT_W-1:0] cnt_ff;
  logic [lfp_pkg::CNT_W-1:0] nxt_cnt;
  localparam logic [lfp_pkg::CNT_W-1:0] LIMIT = lfp_pkg::CNT_W'(CYCLES);

  assign nxt_cnt = !cond ? '0 : (cnt_ff == LIMIT) ? cnt_ff : cnt_ff + 1'b1;
  assign hit     = (cnt_ff == LIMIT);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule : lfp_filter

// File: lfp_threshold.sv
// Maps a 4-bit short threshold code to its comparison level in millivolts.
module lfp_threshold (
  // Code in, level out.
  input  wire logic [3:0] code,
  output logic [9:0]      level_mv
);

  logic [9:0] lin_mv;

  // Codes 1..15 are linear from the base; code 0 is the highest level.
  assign lin_mv   = lfp_pkg::SHORT_BASE_MV
                  + 10'(lfp_pkg::SHORT_STEP_MV * 10'(code - 4'h1));
  assign level_mv = (code == lfp_pkg::SHORT_CODE_TOP) ? lfp_pkg::SHORT_TOP_MV : lin_mv;

endmodule : lfp_threshold

// File: lfp_protect.sv
// Two-channel fault detection, flagging and recovery for an LED DC/DC controller.
//
// Summary of operation
// - Each channel has a 4-bit code selecting one of 16 short levels.
// - Codes 1..15 rise linearly from 45 mV; code 0 is 726 mV; reset 2.
// - Code also goes to the fast discharge logic, never to overvoltage.
// - Buck: pin is current monitor; boost: pin can drive input disconnect.
// - When a short clears, the channel restarts through soft start.
// - Overvoltage sets its flag and stops switching with that channel's gate off.
// - Unlatched overvoltage resumes once sense drops below threshold less hysteresis.
// - With latch enabled, overvoltage stays flagged and stopped until software acts.
// - Clear-latch write clears the overvoltage flag and restarts switching.
// - Overcurrent sets its flag and puts the output stage in high impedance.
// - Overcurrent clears itself once current drops below the falling threshold.
// - Open load needs high sense and low current for eight cycles.
// - Open load is ignored while soft start is still rising.
// - Open load sets its flag and leaves switching untouched.
// - Monitor start launches the routine; done rises with the result.
// - Result is a 2-bit window compare of current sense against the DAC.
// - Temperature warning follows the comparator and never latches.
// - Shutdown stops drivers and regulator, latches its flag; drivers auto restart.
// - After shutdown clears, operation resumes through soft start.
// - Short: low sense 8 cycles, or in boost high current or low node 2 cycles.
// - Short sets its flag, stops output current, then restarts via soft start.
// - Overtemperature shutdown overrides every other fault.
// - Boost pin select low gives PWM mirror plus short flag; high gives current.
module lfp_protect #(
  parameter int NUM_CH = lfp_pkg::NUM_CH
) (
  // Clock and reset.
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  // Software control per channel; clear_latch and clear_temp_shutdown are shared.
  input  wire logic [NUM_CH-1:0]        short_code_we,
  input  wire logic [NUM_CH*4-1:0]      short_code_wdata,
  input  wire logic [NUM_CH-1:0]        overvoltage_latch_enable,
  input  wire logic                     clear_latch,
  input  wire logic [NUM_CH-1:0]        monitor_start,
  input  wire logic [NUM_CH-1:0]        pin_function_select,
  input  wire logic                     clear_temp_shutdown,
  // Analog comparators per channel.
  input  wire logic [NUM_CH-1:0]        topology_select_pin,
  input  wire logic [NUM_CH-1:0]        vfb_below_short,
  input  wire logic [NUM_CH-1:0]        vfb_above_ov,
  input  wire logic [NUM_CH-1:0]        vfb_below_ov_hyst,
  input  wire logic [NUM_CH-1:0]        fb_diff_above_oc_rise,
  input  wire logic [NUM_CH-1:0]        fb_diff_below_oc_fall,
  input  wire logic [NUM_CH-1:0]        fb_diff_above_short,
  input  wire logic [NUM_CH-1:0]        fbh_below_short,
  input  wire logic [NUM_CH-1:0]        vfb_above_open_load,
  input  wire logic [NUM_CH-1:0]        fb_diff_below_ol_ref,
  input  wire logic [NUM_CH-1:0]        soft_start_rising,
  input  wire logic [NUM_CH-1:0]        pwm_active,
  input  wire logic [NUM_CH*8-1:0]      led_sense_code,
  input  wire logic [NUM_CH*8-1:0]      dimming_dac_code,
  input  wire logic [NUM_CH-1:0]        monitor_conv_done,
  // Temperature comparators.
  input  wire logic                     temp_above_warning,
  input  wire logic                     temp_above_shutdown,
  // Configuration and fault flags to software.
  output logic [NUM_CH*4-1:0]           short_threshold_code,
  output logic [NUM_CH*10-1:0]          short_level_mv,
  output logic [NUM_CH-1:0]             overvoltage_flag,
  output logic [NUM_CH-1:0]             overcurrent_flag,
  output logic [NUM_CH-1:0]             open_load_flag,
  output logic [NUM_CH-1:0]             short_flag,
  output logic [NUM_CH-1:0]             monitor_done,
  output logic [NUM_CH*2-1:0]           monitor_result,
  output logic                          temp_warning_flag,
  output logic                          temp_shutdown_flag,
  // Power stage control.
  output logic [NUM_CH-1:0]             gate_enable,
  output logic [NUM_CH-1:0]             soft_start_request,
  output logic                          regulator_enable,
  output logic [NUM_CH-1:0]             monitor_or_short_pin,
  output logic [NUM_CH-1:0]             monitor_pin_is_current
);

  logic tw_ff;
  logic tsd_flag_ff;
  logic tsd_act_ff;

  // Temperature flags are shared by both channels.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tw_ff       <= 1'b0;
      tsd_flag_ff <= 1'b0;
      tsd_act_ff  <= 1'b0;
    end else begin
      tw_ff       <= temp_above_warning;
      tsd_flag_ff <= temp_above_shutdown | (tsd_flag_ff & ~clear_temp_shutdown);
      tsd_act_ff  <= temp_above_shutdown;
    end
  end

  assign temp_warning_flag  = tw_ff;
  assign temp_shutdown_flag = tsd_flag_ff;
  assign regulator_enable   = ~tsd_act_ff;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      logic [3:0] code_ff;
      logic       ov_ff;
      logic       oc_ff;
      logic       ol_ff;
      logic       sc_ff;
      logic       sc_hold_ff;
      logic       ss_ff;
      logic       mon_busy_ff;
      logic       mon_done_ff;
      logic [1:0] mon_res_ff;
      logic       boost;
      logic       vfb_hit;
      logic       diff_hit;
      logic       fbh_hit;
      logic       ol_hit;
      logic       short_now;
      logic       nxt_ov;
      logic       nxt_oc;
      logic       stop_sw;
      logic       restart;
      logic [7:0] sense;
      logic [7:0] dac;
      logic [1:0] nxt_res;
      logic [9:0] level;

      assign boost = topology_select_pin[ch];
      assign sense = led_sense_code[ch*8 +: 8];
      assign dac   = dimming_dac_code[ch*8 +: 8];

      // The level also feeds fast discharge logic outside; overvoltage ignores it.
      lfp_threshold u_thr (
        .code     (code_ff),
        .level_mv (level)
      );

      // Soft start masks the divider short check as well as open load.
      lfp_filter #(.CYCLES(lfp_pkg::VFB_SHORT_CYC)) u_vfb (
        .clk     (clk),
        .sys_rst (sys_rst),
        .cond    (vfb_below_short[ch] & ~soft_start_rising[ch]),
        .hit     (vfb_hit)
      );
      lfp_filter #(.CYCLES(lfp_pkg::BOOST_SHORT_CYC)) u_diff (
        .clk     (clk),
        .sys_rst (sys_rst),
        .cond    (boost & fb_diff_above_short[ch]),
        .hit     (diff_hit)
      );
      lfp_filter #(.CYCLES(lfp_pkg::BOOST_SHORT_CYC)) u_fbh (
        .clk     (clk),
        .sys_rst (sys_rst),
        .cond    (boost & fbh_below_short[ch]),
        .hit     (fbh_hit)
      );
      lfp_filter #(.CYCLES(lfp_pkg::OPEN_LOAD_CYC)) u_ol (
        .clk     (clk),
        .sys_rst (sys_rst),
        .cond    (vfb_above_open_load[ch] & fb_diff_below_ol_ref[ch]
                  & ~soft_start_rising[ch]),
        .hit     (ol_hit)
      );

      assign short_now = vfb_hit | diff_hit | fbh_hit;

      // Latched overvoltage only leaves on clear; unlatched follows hysteresis.
      assign nxt_ov = vfb_above_ov[ch] ? 1'b1
                    : (overvoltage_latch_enable[ch] ? ~clear_latch
                       : ~vfb_below_ov_hyst[ch]) & ov_ff;
      assign nxt_oc = fb_diff_above_oc_rise[ch] ? 1'b1
                    : (oc_ff & ~fb_diff_below_oc_fall[ch]);

      // Overtemperature wins over every other fault.
      assign stop_sw = tsd_act_ff | ov_ff | oc_ff | sc_ff;
      // Leaving short or overtemperature requires a fresh soft start.
      // The restart follows the live condition, not the flag, so an early clear cannot skip it.
      assign restart = (sc_hold_ff & ~sc_ff) | (tsd_act_ff & ~temp_above_shutdown)
                     | (ov_ff & ~nxt_ov);

      // Window compare of sense against DAC, one LSB either side.
      // Nine bits so that a full-scale code cannot wrap the window edge.
      assign nxt_res = ({1'b0, sense} > {1'b0, dac} + 9'h001) ? 2'b11
                     : ({1'b0, sense} + 9'h001 < {1'b0, dac}) ? 2'b00
                     : (sense >= dac) ? 2'b10 : 2'b01;

      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          code_ff     <= lfp_pkg::SHORT_CODE_RST;
          ov_ff       <= 1'b0;
          oc_ff       <= 1'b0;
          ol_ff       <= 1'b0;
          sc_ff       <= 1'b0;
          sc_hold_ff  <= 1'b0;
          ss_ff       <= 1'b0;
          mon_busy_ff <= 1'b0;
          mon_done_ff <= 1'b0;
          mon_res_ff  <= 2'b00;
        end else begin
          if (short_code_we[ch]) begin
            code_ff <= short_code_wdata[ch*4 +: 4];
          end
          ov_ff      <= nxt_ov;
          oc_ff      <= nxt_oc;
          ol_ff      <= ol_hit;
          sc_ff      <= short_now;
          sc_hold_ff <= sc_ff;
          ss_ff      <= restart;
          if (monitor_start[ch]) begin
            mon_busy_ff <= 1'b1;
            mon_done_ff <= 1'b0;
          end else if (mon_busy_ff && monitor_conv_done[ch]) begin
            mon_busy_ff <= 1'b0;
            mon_done_ff <= 1'b1;
            mon_res_ff  <= nxt_res;
          end
        end
      end

      assign short_threshold_code[ch*4 +: 4] = code_ff;
      assign short_level_mv[ch*10 +: 10]     = level;
      assign overvoltage_flag[ch]            = ov_ff;
      assign overcurrent_flag[ch]            = oc_ff;
      assign open_load_flag[ch]              = ol_ff;
      assign short_flag[ch]                  = sc_ff;
      assign monitor_done[ch]                = mon_done_ff;
      assign monitor_result[ch*2 +: 2]       = mon_res_ff;
      assign gate_enable[ch]                 = ~stop_sw;
      assign soft_start_request[ch]          = ss_ff;
      // Buck always monitors current; boost follows the select bit.
      assign monitor_pin_is_current[ch]      = ~boost | pin_function_select[ch];
      assign monitor_or_short_pin[ch]        = monitor_pin_is_current[ch] ? 1'b0
                                             : (pwm_active[ch] & ~sc_ff);

      ov_stop_a: assert property (@(posedge clk) disable iff (sys_rst)
        ov_ff |-> !gate_enable[ch])
        else $error("gate enabled during overvoltage");
      ov_latch_a: assert property (@(posedge clk) disable iff (sys_rst)
        ov_ff && overvoltage_latch_enable[ch] && !clear_latch && !vfb_above_ov[ch]
        |=> ov_ff)
        else $error("latched overvoltage dropped without clear");
      ov_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
        ov_ff && overvoltage_latch_enable[ch] && clear_latch && !vfb_above_ov[ch]
        |=> !ov_ff && soft_start_request[ch])
        else $error("clear latch did not restart");
      oc_set_a: assert property (@(posedge clk) disable iff (sys_rst)
        fb_diff_above_oc_rise[ch] |=> oc_ff && !gate_enable[ch])
        else $error("overcurrent not flagged");
      ol_needs_a: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(ol_ff) |-> $past(vfb_above_open_load[ch], 2)
        && $past(fb_diff_below_ol_ref[ch], 9))
        else $error("open load flagged too early");
      ol_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
        soft_start_rising[ch] [*8] |=> !ol_ff)
        else $error("open load during soft start");
      short_boost_a: assert property (@(posedge clk) disable iff (sys_rst)
        boost && fbh_below_short[ch] [*3] |=> sc_ff)
        else $error("boost short not detected");
      mon_done_a: assert property (@(posedge clk) disable iff (sys_rst)
        monitor_start[ch] |=> !monitor_done[ch])
        else $error("monitor done not cleared on start");
    end
  endgenerate

  tsd_prio_a: assert property (@(posedge clk) disable iff (sys_rst)
    temp_above_shutdown |=> gate_enable == '0 && !regulator_enable)
    else $error("shutdown did not stop drivers");
  tw_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
    !temp_above_warning |=> !temp_warning_flag)
    else $error("warning flag latched");
  tsd_latch_a: assert property (@(posedge clk) disable iff (sys_rst)
    temp_shutdown_flag && !clear_temp_shutdown |=> temp_shutdown_flag)
    else $error("shutdown flag lost");

endmodule : lfp_protect

// File: lfp_partner.sv
// Behavioural analog comparators and monitor converter for one LED channel.
module lfp_partner #(
  parameter int OV_MV    = 1460,
  parameter int OV_HYS   = 40,
  parameter int OC_RISE  = 205,
  parameter int OC_FALL  = 185,
  parameter int S2G_DIFF = 275,
  parameter int S2G_FBH  = 1250,
  parameter int OL_MV    = 1340,
  parameter int OL_REF   = 15,
  parameter int CONV_CYC = 5
) (
  // Clock and analog levels in millivolts.
  input  wire logic        clk,
  input  wire logic [9:0]  short_level_mv,
  input  wire logic [11:0] vfb_mv,
  input  wire logic [11:0] diff_mv,
  input  wire logic [11:0] fbh_mv,
  input  wire logic        monitor_start,
  // Comparator decisions and converter done.
  output logic             vfb_below_short,
  output logic             vfb_above_ov,
  output logic             vfb_below_ov_hyst,
  output logic             fb_diff_above_oc_rise,
  output logic             fb_diff_below_oc_fall,
  output logic             fb_diff_above_short,
  output logic             fbh_below_short,
  output logic             vfb_above_open_load,
  output logic             fb_diff_below_ol_ref,
  output logic             monitor_conv_done
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0] conv_cnt_ff = 4'h0;

  // Decisions settle one clock after the level moves, as a real front end would.
  always @(posedge clk) begin
    vfb_below_short       <= vfb_mv < {2'h0, short_level_mv};
    vfb_above_ov          <= int'(vfb_mv) > OV_MV;
    vfb_below_ov_hyst     <= int'(vfb_mv) < OV_MV - OV_HYS;
    fb_diff_above_oc_rise <= int'(diff_mv) > OC_RISE;
    fb_diff_below_oc_fall <= int'(diff_mv) < OC_FALL;
    fb_diff_above_short   <= int'(diff_mv) > S2G_DIFF;
    fbh_below_short       <= int'(fbh_mv) < S2G_FBH;
    vfb_above_open_load   <= int'(vfb_mv) > OL_MV;
    fb_diff_below_ol_ref  <= int'(diff_mv) < OL_REF;
  end

  // Done answers only a start, so a design that skips its busy state is exposed.
  always @(posedge clk) begin
    monitor_conv_done <= 1'b0;
    if (monitor_start) begin
      conv_cnt_ff <= 4'(CONV_CYC);
    end else if (conv_cnt_ff != 4'h0) begin
      conv_cnt_ff       <= conv_cnt_ff - 4'h1;
      monitor_conv_done <= conv_cnt_ff == 4'h1;
    end
  end
endmodule : lfp_partner

// File: lfp_protect_bench.sv
// Self-checking bench for the two-channel LED fault protection block.
module lfp_protect_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int N = lfp_pkg::NUM_CH;
  logic              clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic [N-1:0]      short_code_we, overvoltage_latch_enable, monitor_start, pin_function_select;
  logic [N-1:0]      topology_select_pin, soft_start_rising, pwm_active;
  logic [N*4-1:0]    short_code_wdata, short_threshold_code;
  logic              clear_latch, clear_temp_shutdown, temp_above_warning, temp_above_shutdown;
  logic [N*8-1:0]    led_sense_code, dimming_dac_code;
  logic [11:0]       vfb_mv [N];
  logic [11:0]       diff_mv [N];
  logic [11:0]       fbh_mv [N];
  wire logic [N-1:0] vfb_below_short, vfb_above_ov, vfb_below_ov_hyst, fb_diff_above_oc_rise;
  wire logic [N-1:0] fb_diff_below_oc_fall, fb_diff_above_short, fbh_below_short;
  wire logic [N-1:0] vfb_above_open_load, fb_diff_below_ol_ref, monitor_conv_done;
  logic [N*10-1:0]   short_level_mv;
  logic [N-1:0]      overvoltage_flag, overcurrent_flag, open_load_flag, short_flag, monitor_done;
  logic [N*2-1:0]    monitor_result;
  logic              temp_warning_flag, temp_shutdown_flag, regulator_enable;
  logic [N-1:0]      gate_enable, soft_start_request, monitor_or_short_pin, monitor_pin_is_current;
  int                bad_count = 0;
  int                samples_checked = 0;
  int                ss_cnt = 0;
  int                seed = 60;

  lfp_protect #(.NUM_CH(N)) i_lfp_protect (
    .clk(clk), .sys_rst(sys_rst), .short_code_we(short_code_we),
    .short_code_wdata(short_code_wdata), .overvoltage_latch_enable(overvoltage_latch_enable),
    .clear_latch(clear_latch), .monitor_start(monitor_start),
    .pin_function_select(pin_function_select), .clear_temp_shutdown(clear_temp_shutdown),
    .topology_select_pin(topology_select_pin), .vfb_below_short(vfb_below_short),
    .vfb_above_ov(vfb_above_ov), .vfb_below_ov_hyst(vfb_below_ov_hyst),
    .fb_diff_above_oc_rise(fb_diff_above_oc_rise), .fb_diff_below_oc_fall(fb_diff_below_oc_fall),
    .fb_diff_above_short(fb_diff_above_short), .fbh_below_short(fbh_below_short),
    .vfb_above_open_load(vfb_above_open_load), .fb_diff_below_ol_ref(fb_diff_below_ol_ref),
    .soft_start_rising(soft_start_rising), .pwm_active(pwm_active),
    .led_sense_code(led_sense_code), .dimming_dac_code(dimming_dac_code),
    .monitor_conv_done(monitor_conv_done), .temp_above_warning(temp_above_warning),
    .temp_above_shutdown(temp_above_shutdown), .short_threshold_code(short_threshold_code),
    .short_level_mv(short_level_mv), .overvoltage_flag(overvoltage_flag),
    .overcurrent_flag(overcurrent_flag), .open_load_flag(open_load_flag),
    .short_flag(short_flag), .monitor_done(monitor_done), .monitor_result(monitor_result),
    .temp_warning_flag(temp_warning_flag), .temp_shutdown_flag(temp_shutdown_flag),
    .gate_enable(gate_enable), .soft_start_request(soft_start_request),
    .regulator_enable(regulator_enable), .monitor_or_short_pin(monitor_or_short_pin),
    .monitor_pin_is_current(monitor_pin_is_current)
  );

  for (genvar c = 0; c < N; c++) begin : g_ch
    lfp_partner i_lfp_partner (
      .clk(clk), .short_level_mv(short_level_mv[c*10+:10]), .vfb_mv(vfb_mv[c]),
      .diff_mv(diff_mv[c]), .fbh_mv(fbh_mv[c]), .monitor_start(monitor_start[c]),
      .vfb_below_short(vfb_below_short[c]), .vfb_above_ov(vfb_above_ov[c]),
      .vfb_below_ov_hyst(vfb_below_ov_hyst[c]), .fb_diff_above_oc_rise(fb_diff_above_oc_rise[c]),
      .fb_diff_below_oc_fall(fb_diff_below_oc_fall[c]),
      .fb_diff_above_short(fb_diff_above_short[c]), .fbh_below_short(fbh_below_short[c]),
      .vfb_above_open_load(vfb_above_open_load[c]), .fb_diff_below_ol_ref(fb_diff_below_ol_ref[c]),
      .monitor_conv_done(monitor_conv_done[c])
    );
  end

  initial begin
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    if (soft_start_request[0] === 1'b1) ss_cnt <= ss_cnt + 1;
  end

  function automatic logic [9:0] exp_level(input logic [3:0] code);
    return (code == 4'h0) ? 10'd726 : 10'(int'(code) * 45);
  endfunction : exp_level

  // Host side: the code is the wanted short voltage times the divider ratio over a 45 mV step.
  function automatic logic [3:0] host_code(input int v_mv, input int k_num, input int k_den);
    return 4'((v_mv * k_num / k_den) / 45);
  endfunction : host_code

  function automatic logic [1:0] exp_mon(input int s, input int d);
    if (s > d + 1) return 2'h3;
    if (s + 1 < d) return 2'h0;
    return (s >= d) ? 2'h2 : 2'h1;
  endfunction : exp_mon

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic set_ana(input int c, input int v, input int d, input int f);
    @(posedge clk);
    vfb_mv[c]  <= 12'(v);
    diff_mv[c] <= 12'(d);
    fbh_mv[c]  <= 12'(f);
  endtask : set_ana

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  initial begin
    int b, s, d, c, n;
    logic [3:0] code;
    {short_code_we, overvoltage_latch_enable, monitor_start, pin_function_select} = '0;
    {topology_select_pin, soft_start_rising, short_code_wdata, clear_latch} = '0;
    {clear_temp_shutdown, temp_above_warning, temp_above_shutdown} = '0;
    {led_sense_code, dimming_dac_code} = '0;
    pwm_active = '1;
    vfb_mv  = '{default: 12'd1000};
    diff_mv = '{default: 12'd100};
    fbh_mv  = '{default: 12'd2000};
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    tick(1);
    chk("code_rst", 8'h22, short_threshold_code);
    for (int k = 0; k < 17; k++) begin
      code = (k == 16) ? host_code(3500, 1500, 57500) : 4'(k);
      @(posedge clk);
      short_code_we    <= '1;
      short_code_wdata <= {~code, code};
      @(posedge clk);
      short_code_we    <= '0;
      tick(1);
      chk("level0", exp_level(code), short_level_mv[9:0]);
      chk("level1", exp_level(~code), short_level_mv[19:10]);
    end
    b = ss_cnt;
    set_ana(0, 1500, 100, 2000); tick(3);
    chk("ov_flag", 2'b01, overvoltage_flag);
    chk("ov_gate", 2'b10, gate_enable);
    set_ana(0, 1440, 100, 2000); tick(3);
    chk("ov_hyst", 2'b01, overvoltage_flag);
    set_ana(0, 1000, 100, 2000); tick(4);
    chk("ov_clr", 2'b00, overvoltage_flag);
    chk("ov_ss", b + 1, ss_cnt);
    overvoltage_latch_enable <= 2'b10;
    set_ana(1, 1500, 100, 2000); tick(3);
    set_ana(1, 1000, 100, 2000); tick(6);
    chk("ovl_hold", 2'b10, overvoltage_flag);
    chk("ovl_gate", 2'b01, gate_enable);
    @(posedge clk);
    clear_latch <= 1'b1;
    @(posedge clk);
    clear_latch <= 1'b0;
    tick(3);
    chk("ovl_clr", 4'h3, {overvoltage_flag, gate_enable});
    // Back to auto-restart so that later overvoltage on this channel recovers alone.
    overvoltage_latch_enable <= 2'b00;
    set_ana(1, 1000, 250, 2000); tick(3);
    chk("oc_set", 4'h9, {overcurrent_flag, gate_enable});
    set_ana(1, 1000, 195, 2000); tick(3);
    chk("oc_hyst", 2'b10, overcurrent_flag);
    set_ana(1, 1000, 100, 2000); tick(3);
    chk("oc_clr", 4'h3, {overcurrent_flag, gate_enable});
    soft_start_rising <= 2'b10;
    set_ana(0, 1350, 5, 2000); set_ana(1, 1350, 5, 2000); tick(5);
    chk("ol_early", 2'b00, open_load_flag);
    tick(9);
    chk("ol_set", 4'h7, {open_load_flag, gate_enable});
    set_ana(0, 1000, 100, 2000); set_ana(1, 1000, 100, 2000);
    soft_start_rising <= 2'b00;
    b = ss_cnt;
    set_ana(0, 80, 100, 2000); tick(6);
    chk("vs_early", 1'b0, short_flag[0]);
    tick(8);
    chk("vs_set", 2'b10, {short_flag[0], gate_enable[0]});
    set_ana(0, 1000, 100, 2000); tick(5);
    chk("vs_restart", 1'b1, gate_enable[0]);
    chk("vs_ss", b + 1, ss_cnt);
    chk("buck_pin", 2'b11, monitor_pin_is_current);
    topology_select_pin <= 2'b11;
    set_ana(0, 1000, 100, 1000); set_ana(1, 1000, 300, 2000); tick(5);
    chk("bs_set", 4'hC, {short_flag, gate_enable});
    chk("bs_pin", 1'b0, monitor_or_short_pin[0]);
    set_ana(0, 1000, 100, 2000); set_ana(1, 1000, 100, 2000);
    pin_function_select <= 2'b01;
    tick(6);
    chk("bs_cur", 2'b10, {monitor_pin_is_current[0], monitor_or_short_pin[0]});
    temp_above_warning <= 1'b1; tick(2);
    chk("tw_set", 1'b1, temp_warning_flag);
    temp_above_warning <= 1'b0; tick(2);
    chk("tw_clr", 1'b0, temp_warning_flag);
    b = ss_cnt;
    temp_above_shutdown <= 1'b1; set_ana(1, 1500, 100, 2000); tick(3);
    chk("tsd_set", 4'h8, {temp_shutdown_flag, regulator_enable, gate_enable});
    temp_above_shutdown <= 1'b0; set_ana(1, 1000, 100, 2000); tick(5);
    chk("tsd_hold", 4'hF, {temp_shutdown_flag, regulator_enable, gate_enable});
    chk("tsd_ss", b + 1, ss_cnt);
    clear_temp_shutdown <= 1'b1; tick(1);
    clear_temp_shutdown <= 1'b0; tick(2);
    chk("tsd_clr", 1'b0, temp_shutdown_flag);
    for (int i = 0; i < 10; i++) begin
      c = i % N;
      d = 8 + (($random(seed) & 255) % 240);
      s = (i == 0) ? d : d + ($random(seed) % 4);
      @(posedge clk);
      led_sense_code[c*8+:8]   <= 8'(s);
      dimming_dac_code[c*8+:8] <= 8'(d);
      monitor_start[c]         <= 1'b1;
      @(posedge clk);
      monitor_start[c] <= 1'b0;
      tick(1);
      chk("mon_busy", 1'b0, monitor_done[c]);
      for (n = 0; n < 20 && monitor_done[c] !== 1'b1; n++) tick(1);
      chk("mon_res", {1'b1, exp_mon(s, d)}, {monitor_done[c], monitor_result[c*2+:2]});
    end
    report_and_stop();
  end

  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end
endmodule : lfp_protect_bench
